// [asrp_readout_port.sv]
// Serial readout port of a 16-bit converter: shares parallel pins 6 to 8 with the serial port,
// drives or follows the bit clock, and has its configuration in APB registers.
// Assumes the converter core is on pclk and hands results over with valid/ready.
`default_nettype none
`include "asrp_consts.svh"
// Operation
// - In parallel mode the three shared pins carry bits 6, 7 and 8 of the held result.
// - In serial mode the bit clock is inverted while the invert pin is high, as master and as slave.
// - In serial mode the shared pin is the chain input with an external clock, else the read-mode select.
// - With an external clock the chain input level reaches the serial output 16 bit clocks after the read starts.
// - Another converter's serial output may feed the chain input so several results share one line.
// - As master with read-mode high the previous result is shifted out while a conversion runs.
// - As master with read-mode low data is shifted out only once the conversion has finished.
// - The serial output changes only in step with the bit clock.
// - Each result is held in a register and shifted out most significant bit first.
// - The coding of the output word follows the output-coding select.
// - As master with PHASE_CYC above 1 the serial output is stable at both edges of the bit clock.
// - As slave without inversion the output changes on the rising edge and is sampled on the falling one.
// - As slave with inversion the output changes on the falling edge and is sampled on the rising one.
// - Port-select high gives serial mode on the shared pins and low gives parallel mode.
// - In serial mode, with the clock source low the port drives its own bit clock out, else the other party supplies it.
// - Coding select high gives straight binary, low inverts the top bit for twos complement.
module asrp_readout_port #(
  parameter int WORD_BITS = `ASRP_WORD_BITS,
  parameter int PHASE_CYC = `ASRP_MCLK_PHASE_CYC
) (
  // System
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave
  input wire asrp_pkg::asrp_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter core
  input wire logic conv_busy,
  input wire logic result_valid,
  input wire logic [WORD_BITS-1:0] result_data,
  output logic result_ready,
  // Shared pins for parallel bits 6, 7 and 8
  input wire logic [2:0] pin_i,
  output logic [2:0] pin_o,
  output logic [2:0] pin_oe,
  // Bit clock pin and frame sync
  input wire logic bit_clk_i,
  output logic bit_clk_o,
  output logic bit_clk_oe,
  output logic frame_sync_o
);
  localparam int DW = (PHASE_CYC > 1) ? $clog2(PHASE_CYC) : 1;
  asrp_pkg::asrp_ctrl_t ctrl;
  asrp_pkg::asrp_state_t state;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic clk_prev;
  logic conv_prev;
  logic [WORD_BITS-1:0] held_word;
  logic fresh;
  logic [WORD_BITS-1:0] shreg;
  logic [`ASRP_CNT_W-1:0] cnt;
  logic [DW-1:0] div;
  logic [1:0] phase;
  logic mclk;
  logic buf_valid;
  logic [WORD_BITS-1:0] buf_data;
  logic serial, master, slave, inv, rd_or_chain, during;
  logic rise, fall, tick, upd, pop, start, done, conv_rise, shifting;
  logic [WORD_BITS-1:0] load_word;
  logic [`ASRP_CNT_W-1:0] total;
  logic apb_hit, apb_wr;

  function automatic logic [WORD_BITS-1:0] code(input logic [WORD_BITS-1:0] w, input logic binary);
    code = {w[WORD_BITS-1] ^ ~binary, w[WORD_BITS-2:0]};
  endfunction

  function automatic logic mapped(input logic [`ASRP_ADDR_W-1:0] a);
    mapped = (a == `ASRP_CTRL_OFS) || (a == `ASRP_STAT_OFS) || (a == `ASRP_RES_OFS);
  endfunction

  // Pins from the far side pass two flops; only the second one is read.
  for (genvar g = 0; g < 3; g++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sync1[g] <= 1'b0;
        sync2[g] <= 1'b0;
      end else if (clk_en) begin
        sync1[g] <= (g == `ASRP_SYN_CLK) ? bit_clk_i : pin_i[g];
        sync2[g] <= sync1[g];
      end
    end
  end

  assign serial = ctrl.port_select;
  assign master = serial & ~ctrl.clock_source_select;
  assign slave = serial & ctrl.clock_source_select;
  assign inv = sync2[`ASRP_PIN_INV];
  assign rd_or_chain = sync2[`ASRP_PIN_CHAIN];
  assign during = master & rd_or_chain;
  assign shifting = state == asrp_pkg::ASRP_SHIFT;
  assign rise = sync2[`ASRP_SYN_CLK] & ~clk_prev;
  assign fall = ~sync2[`ASRP_SYN_CLK] & clk_prev;
  assign tick = div == DW'(PHASE_CYC - 1);
  assign conv_rise = conv_busy & ~conv_prev;
  // As slave the update edge is the rising one unless inverted; as master it lies between edges.
  assign upd = shifting & (slave ? (inv ? fall : rise) : (tick & (phase == `ASRP_PH_UPDATE)));
  assign pop = buf_valid & ~shifting & ~(master & ~rd_or_chain & conv_busy);
  assign start = ~shifting & (during ? (conv_rise & fresh) : (serial & pop));
  assign load_word = during ? held_word : buf_data;
  assign total = slave ? `ASRP_CNT_W'(WORD_BITS * (ctrl.chain_len + 1)) : `ASRP_CNT_W'(WORD_BITS);
  assign done = slave ? (upd & (cnt == total - 1'b1)) : (tick & (phase == `ASRP_PH_FALL) & (cnt == total));

  asrp_pair_buffer #(
    .WIDTH(WORD_BITS),
    .DEPTH(`ASRP_BUF_DEPTH)
  ) u_buf (
    .clk(pclk),
    .rst_n(presetn),
    .en(clk_en),
    .in_valid(result_valid),
    .in_ready(result_ready),
    .in_data(result_data),
    .out_valid(buf_valid),
    .out_ready(pop),
    .out_data(buf_data)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_prev <= 1'b0;
      conv_prev <= 1'b0;
    end else if (clk_en) begin
      clk_prev <= sync2[`ASRP_SYN_CLK];
      conv_prev <= conv_busy;
    end
  end

  // The held word is the latest result; fresh marks one not yet sent by a read during conversion, and a new result wins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_word <= '0;
      fresh <= 1'b0;
    end else if (clk_en) begin
      if (pop) begin
        held_word <= buf_data;
        fresh <= 1'b1;
      end else if (start) begin
        fresh <= 1'b0;
      end
    end
  end

  // Leaving serial mode ends a frame at once; the far side must not switch modes mid-read.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= asrp_pkg::ASRP_IDLE;
    end else if (clk_en) begin
      unique case (state)
        asrp_pkg::ASRP_IDLE: begin
          if (start) begin
            state <= asrp_pkg::ASRP_SHIFT;
          end
        end
        asrp_pkg::ASRP_SHIFT: begin
          if (done || !serial) begin
            state <= asrp_pkg::ASRP_IDLE;
          end
        end
      endcase
    end
  end

  // Chain bits enter at the bottom, so they appear one full word after the read begins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg <= '0;
      cnt <= '0;
    end else if (clk_en) begin
      if (start) begin
        shreg <= code(load_word, ctrl.output_coding_select);
        cnt <= '0;
      end else if (upd) begin
        shreg <= {shreg[WORD_BITS-2:0], slave & rd_or_chain};
        cnt <= cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= '0;
      phase <= '0;
      mclk <= 1'b0;
    end else if (clk_en) begin
      if (!shifting || !master) begin
        div <= '0;
        phase <= '0;
        mclk <= 1'b0;
      end else begin
        div <= tick ? '0 : DW'(div + 1'b1);
        if (tick) begin
          phase <= phase + 1'b1;
          if (phase == `ASRP_PH_RISE) begin
            mclk <= 1'b1;
          end else if (phase == `ASRP_PH_FALL) begin
            mclk <= 1'b0;
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_o <= '0;
      pin_oe <= '0;
      bit_clk_o <= 1'b0;
      bit_clk_oe <= 1'b0;
      frame_sync_o <= 1'b0;
    end else if (clk_en) begin
      if (serial) begin
        pin_oe <= `ASRP_OE_SERIAL;
        pin_o[1:0] <= '0;
        if (upd) begin
          pin_o[`ASRP_PIN_OUT] <= shreg[WORD_BITS-1];
        end
      end else begin
        pin_oe <= `ASRP_OE_PARALLEL;
        pin_o <= held_word[`ASRP_PAR_LSB +: 3];
      end
      bit_clk_o <= mclk ^ inv;
      bit_clk_oe <= master;
      frame_sync_o <= (master & shifting & (cnt != '0)) ^ ctrl.frame_sync_polarity;
    end
  end

  // One wait state: pready rises in the second access cycle and the transfer ends there.
  assign apb_hit = apb_req.psel & apb_req.penable & ~pready;
  assign apb_wr = apb_req.psel & apb_req.penable & pready & apb_req.pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else if (clk_en) begin
      pready <= apb_hit;
      pslverr <= apb_hit & ~mapped(apb_req.paddr);
      prdata <= '0;
      if (apb_hit && !apb_req.pwrite) begin
        unique case (apb_req.paddr)
          `ASRP_CTRL_OFS: prdata <= 32'(ctrl);
          `ASRP_STAT_OFS: prdata <= 32'({conv_busy, rd_or_chain, inv, fresh, buf_valid, shifting});
          `ASRP_RES_OFS: prdata <= 32'(held_word);
          default: prdata <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `ASRP_CTRL_RST;
    end else if (clk_en && apb_wr && apb_req.paddr == `ASRP_CTRL_OFS) begin
      ctrl <= asrp_pkg::asrp_ctrl_t'(apb_req.pwdata[`ASRP_CTRL_W-1:0]);
    end
  end

  // The edge that releases reset still runs the reset branch, so the parallel-pin and clock-drive checks start one edge later.
  property p_par_pins;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && $past(presetn) && !serial) |=>
      (pin_oe == `ASRP_OE_PARALLEL) && (pin_o == $past(held_word[`ASRP_PAR_LSB +: 3]));
  endproperty
  a_par_pins: assert property (p_par_pins) else $error("parallel pins do not show the held bits");

  property p_clk_inv;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && master) |=> bit_clk_o == ($past(mclk) ^ $past(inv));
  endproperty
  a_clk_inv: assert property (p_clk_inv) else $error("bit clock does not follow the invert pin");

  property p_chain_in;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && slave && upd && !start) |=> shreg[0] == $past(rd_or_chain);
  endproperty
  a_chain_in: assert property (p_chain_in) else $error("chain input not shifted in");

  property p_during;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && during && !shifting && conv_rise && fresh) |=> shifting ##1 (!clk_en || shifting);
  endproperty
  a_during: assert property (p_during) else $error("read during conversion did not start");

  property p_after;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && master && !rd_or_chain && conv_busy && !shifting) |=> !shifting;
  endproperty
  a_after: assert property (p_after) else $error("shift started before conversion ended");

  property p_msb_first;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && serial && upd) |=> pin_o[`ASRP_PIN_OUT] == $past(shreg[WORD_BITS-1]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("serial output is not the top bit");

  property p_coding;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && start) |=> shreg[WORD_BITS-1] == ($past(load_word[WORD_BITS-1]) ^ !$past(ctrl.output_coding_select));
  endproperty
  a_coding: assert property (p_coding) else $error("top bit coding wrong");

  property p_master_stable;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && master && !upd) |=> $stable(pin_o[`ASRP_PIN_OUT]);
  endproperty
  a_master_stable: assert property (p_master_stable) else $error("output moved away from update slot");

  property p_slave_rise;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && slave && !inv && fall) |=> $stable(pin_o[`ASRP_PIN_OUT]);
  endproperty
  a_slave_rise: assert property (p_slave_rise) else $error("output moved on sampling edge");

  property p_slave_fall;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && slave && inv && rise) |=> $stable(pin_o[`ASRP_PIN_OUT]);
  endproperty
  a_slave_fall: assert property (p_slave_fall) else $error("output moved on inverted sampling edge");

  property p_clk_drive;
    @(posedge pclk) disable iff (!presetn)
    (clk_en && $past(presetn)) |=> (bit_clk_oe == $past(master)) && (pin_oe != '0);
  endproperty
  a_clk_drive: assert property (p_clk_drive) else $error("bit clock drive wrong");
endmodule
`default_nettype wire

// [asrp_consts.svh]
// Constants for the serial readout port: register map, field layout, reset values, timing.
// Assumes it is included by bare name wherever a number is needed.
`ifndef ASRP_CONSTS_SVH
`define ASRP_CONSTS_SVH
`define ASRP_ADDR_W 8
`define ASRP_CTRL_OFS 8'h00
`define ASRP_STAT_OFS 8'h04
`define ASRP_RES_OFS 8'h08
`define ASRP_CTRL_W 6
`define ASRP_CTRL_RST 6'h04
`define ASRP_STAT_W 6
`define ASRP_WORD_BITS 16
`define ASRP_CNT_W 7
`define ASRP_PAR_LSB 6
`define ASRP_PIN_INV 0
`define ASRP_PIN_CHAIN 1
`define ASRP_PIN_OUT 2
`define ASRP_SYN_CLK 2
`define ASRP_OE_SERIAL 3'h4
`define ASRP_OE_PARALLEL 3'h7
`define ASRP_PCLK_NS 5
`define ASRP_MCLK_PHASE_NS 20
`define ASRP_MCLK_PHASE_CYC ((`ASRP_MCLK_PHASE_NS + `ASRP_PCLK_NS - 1) / `ASRP_PCLK_NS)
`define ASRP_PH_UPDATE 2'h0
`define ASRP_PH_RISE 2'h1
`define ASRP_PH_FALL 2'h3
`define ASRP_BUF_DEPTH 2
`endif

// [asrp_pkg.sv]
// Types shared by the serial readout port and its test bench.
// Assumes asrp_consts.svh is on the include path.
`default_nettype none
`include "asrp_consts.svh"
package asrp_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`ASRP_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } asrp_apb_req_t;
  typedef struct packed {
    logic [1:0] chain_len;
    logic frame_sync_polarity;
    logic output_coding_select;
    logic clock_source_select;
    logic port_select;
  } asrp_ctrl_t;
  typedef enum logic {ASRP_IDLE, ASRP_SHIFT} asrp_state_t;
endpackage
`default_nettype wire

// [asrp_pair_buffer.sv]
// Small valid/ready buffer that holds conversion results until the serial port takes them.
// Assumes one clock, an active-low asynchronous reset and a clock enable that freezes it.
`default_nettype none
`include "asrp_consts.svh"
module asrp_pair_buffer #(
  parameter int WIDTH = `ASRP_WORD_BITS,
  parameter int DEPTH = `ASRP_BUF_DEPTH
) (
  // System
  input wire logic clk,
  input wire logic rst_n,
  input wire logic en,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pull;
  logic [PW:0] next_count;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign push = en & in_valid & in_ready;
  assign pull = en & out_valid & out_ready;
  assign out_data = mem[rd_ptr];
  assign next_count = (count + (PW + 1)'(push)) - (PW + 1)'(pull);

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Full and empty are flops so that ready leaves the block without a gate in its path.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else if (en) begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pull) begin
        rd_ptr <= bump(rd_ptr);
      end
      count <= next_count;
      in_ready <= next_count != (PW + 1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end
endmodule
`default_nettype wire

// [asrp_host_model.sv]
// Host serial port model: clocks the link when the port is a slave and samples the serial result.
// Assumes the bench clears it before each frame and owns the invert and chain pins itself.
`default_nettype none
module asrp_host_model (
  // Link pins
  input wire logic sdata,
  input wire logic clk_in,
  output logic clk_out,
  // Bench control
  input wire logic ext_mode,
  input wire logic inv
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] got;
  int n_bits;
  initial begin
    clk_out = 1'b0;
    got = '0;
    n_bits = 0;
  end
  // At PHASE_CYC 1 the device changes data as its own clock returns to idle, so the edge leaving idle is taken.
  always @(clk_in) begin
    if (!ext_mode && clk_in !== inv) begin
      got = {got[30:0], sdata};
      n_bits++;
    end
  end
  task automatic clear();
    got = '0;
    n_bits = 0;
  endtask
  // The clock only runs within a frame and is parked at its idle level, so stray edges stay out.
  task automatic run_frame(input int n);
    clk_out = inv;
    #64;
    repeat (n) begin
      clk_out = !inv;
      #32;
      clk_out = inv;
      got = {got[30:0], sdata};
      n_bits++;
      #32;
    end
  endtask
endmodule
`default_nettype wire

// [asrp_readout_port_test.sv]
// Self-checking bench for the serial readout port, with a host model on the serial link.
// Assumes the package, the buffer, the port and the host model are compiled before it.
`default_nettype none
`include "asrp_consts.svh"
module asrp_readout_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {
    logic [15:0] word;
    logic [2:0] pins;
  } asrp_row_t;
  asrp_row_t rows [4] = '{'{16'h01C0, 3'h7}, '{16'h0040, 3'h1}, '{16'h0080, 3'h2}, '{16'hFE3F, 3'h0}};
  logic pclk, presetn, clk_en, conv_busy, result_valid, result_ready, pready, pslverr, err;
  logic bit_clk_o, bit_clk_oe, frame_sync_o, host_clk, clk_w, ext_mode;
  logic [15:0] result_data;
  logic [31:0] prdata, rd;
  logic [2:0] pin_o, pin_oe, pin_ext, pin_w;
  asrp_pkg::asrp_apb_req_t apb_req;
  int fails, n_compared;
  // Shared pins and the clock pin are resolved from the port's output enables.
  assign pin_w = (pin_oe & pin_o) | (~pin_oe & pin_ext);
  assign clk_w = bit_clk_oe ? bit_clk_o : host_clk;
  asrp_readout_port #(.PHASE_CYC(1)) dut (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_busy(conv_busy), .result_valid(result_valid), .result_data(result_data),
    .result_ready(result_ready), .pin_i(pin_w), .pin_o(pin_o), .pin_oe(pin_oe),
    .bit_clk_i(clk_w), .bit_clk_o(bit_clk_o), .bit_clk_oe(bit_clk_oe), .frame_sync_o(frame_sync_o)
  );
  asrp_host_model host (
    .sdata(pin_w[2]), .clk_in(clk_w), .clk_out(host_clk), .ext_mode(ext_mode), .inv(pin_ext[0])
  );
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask
  task automatic final_report();
    $display("Checks made %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) check("apb_answer", 32'h1, 32'h0);
    apb_req <= '0;
  endtask
  // The source holds its word until the buffer shows room at a sampling edge.
  task automatic push(input logic [15:0] w);
    int k;
    @(posedge pclk);
    result_valid <= 1'b1;
    result_data <= w;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (result_ready !== 1'b1 && k < 100);
    result_valid <= 1'b0;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    final_report();
  end
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    conv_busy = 1'b0;
    result_valid = 1'b0;
    result_data = '0;
    pin_ext = 3'h0;
    apb_req = '0;
    ext_mode = 1'b0;
    fails = 0;
    n_compared = 0;
    repeat (4) @(posedge pclk);
    check("pin_oe_in_reset", 32'h0, 32'(pin_oe));
    check("ready_in_reset", 32'h1, 32'(result_ready));
    presetn <= 1'b1;
    idle(3);
    check("parallel_oe", 32'h7, 32'(pin_oe));
    apb(1'b0, `ASRP_CTRL_OFS, 32'h0);
    check("ctrl_reset", 32'h4, rd);
    check("mapped_err", 32'h0, 32'(err));
    foreach (rows[i]) begin
      push(rows[i].word);
      idle(8);
      check("parallel_pins", 32'(rows[i].pins), 32'(pin_w));
      apb(1'b0, `ASRP_RES_OFS, 32'h0);
      check("held_result", 32'(rows[i].word), rd);
    end
    apb(1'b0, 8'h0C, 32'h0);
    check("unmapped_err", 32'h1, 32'(err));
    check("unmapped_data", 32'h0, rd);
    // Master, read after conversion, twos complement.
    apb(1'b1, `ASRP_CTRL_OFS, 32'h01);
    conv_busy <= 1'b1;
    idle(6);
    check("serial_oe", 32'h4, 32'(pin_oe));
    check("master_clk_oe", 32'h1, 32'(bit_clk_oe));
    host.clear();
    push(16'hA5C3);
    idle(60);
    check("after_mode_quiet", 32'h0, 32'(host.n_bits));
    conv_busy <= 1'b0;
    idle(150);
    check("after_mode_word", 32'h25C3, 32'(host.got[15:0]));
    check("after_mode_bits", 32'h10, 32'(host.n_bits));
    // Master, read during conversion, inverted clock, straight binary.
    pin_ext <= 3'h3;
    apb(1'b1, `ASRP_CTRL_OFS, 32'h05);
    idle(8);
    check("inverted_idle_clk", 32'h1, 32'(clk_w));
    host.clear();
    conv_busy <= 1'b1;
    idle(20);
    check("frame_sync_active", 32'h1, 32'(frame_sync_o));
    idle(130);
    check("frame_sync_idle", 32'h0, 32'(frame_sync_o));
    check("during_mode_word", 32'hA5C3, 32'(host.got[15:0]));
    check("during_mode_bits", 32'h10, 32'(host.n_bits));
    conv_busy <= 1'b0;
    // Slave with one chained converter whose output stands high.
    ext_mode <= 1'b1;
    pin_ext <= 3'h2;
    apb(1'b1, `ASRP_CTRL_OFS, 32'h17);
    idle(2);
    check("slave_clk_oe", 32'h0, 32'(bit_clk_oe));
    host.clear();
    push(16'h1234);
    idle(4);
    host.run_frame(32);
    check("chain_frame", 32'h1234FFFF, host.got);
    // Slave with inverted clock and no chain.
    pin_ext <= 3'h1;
    apb(1'b1, `ASRP_CTRL_OFS, 32'h07);
    host.clear();
    push(16'h81C1);
    idle(4);
    host.run_frame(16);
    check("inverted_slave_word", 32'h81C1, 32'(host.got[15:0]));
    apb(1'b1, `ASRP_CTRL_OFS, 32'h04);
    idle(6);
    check("back_to_parallel", 32'h7, 32'(pin_oe));
    check("back_to_parallel_pins", 32'h7, 32'(pin_w));
    // A word offered while the enable is low must not be taken, so the pins keep the old result.
    clk_en <= 1'b0;
    push(16'h0000);
    idle(2);
    clk_en <= 1'b1;
    idle(6);
    check("frozen_pins", 32'h7, 32'(pin_w));
    final_report();
  end
endmodule
`default_nettype wire
